// ### rtl/cfed_fault_detect.sv
module cfed_fault_detect
  import cfed_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // pipeline and bus interface
  input  wire logic        iss_valid,
  input  cfed_issue_t      iss,
  input  wire logic        sr_trace,
  input  wire logic        sr_super,
  input  wire logic        pf_err,
  input  wire logic        pf_flush,
  input  wire logic        rd_err,
  input  wire logic        wr_err,
  input  wire logic        wr_busy,
  // exception report
  output logic             exc_valid_r,
  output cfed_report_t     exc_r,
  output logic             nop_stall_r
);

  cfed_decode_t dec;
  cfed_state_t  st_r;
  cfed_state_t  st_nxt;
  cfed_report_t rep_nxt;
  logic         take_nxt;
  logic         pf_pend_r;
  logic         wr_pend_r;
  logic         uha_r;
  logic [7:0]   last_vec_r;
  logic [3:0]   last_fs_r;
  logic [15:0]  cnt_r;
  logic         nop_hold;
  logic         pf_hit;
  logic         c_rd;
  logic         c_pf;
  logic         c_wr;
  logic         c_ill;
  logic         c_priv;
  logic         c_idx;
  logic         c_odd;
  logic         c_div;
  logic         c_trc;
  logic         acc_ok;

  // ----------------------------------------------------------------
  // opword decoder
  // ----------------------------------------------------------------
  cfed_opword_decode u_dec (
    .opword     (iss.opword),
    .ext1       (iss.ext1),
    .has_ext1   (iss.has_ext1),
    .has_ext2   (iss.has_ext2),
    .op_defined (iss.op_defined),
    .is_mac     (iss.is_mac),
    .has_index  (iss.has_index),
    .dec        (dec)
  );

  // ----------------------------------------------------------------
  // raw fault causes at the execute stage
  // ----------------------------------------------------------------
  // no-op holds while writes drain
  assign nop_hold = iss_valid && iss.is_nop && (wr_busy || wr_err);
  assign pf_hit   = iss.uses_pf_word && (pf_pend_r || pf_err);
  assign c_rd     = rd_err;
  assign c_pf     = iss_valid && !nop_hold && pf_hit;
  assign c_wr     = iss_valid && !nop_hold && wr_pend_r;
  assign c_ill    = iss_valid && !nop_hold && dec.illegal;
  assign c_priv   = iss_valid && !nop_hold && iss.super_only &&
                    !sr_super && !(iss.is_halt && uha_r);
  assign c_idx    = iss_valid && !nop_hold && dec.idx_bad;
  assign c_odd    = iss_valid && !nop_hold && iss.is_flow &&
                    iss.target_odd;
  assign c_div    = iss_valid && !nop_hold && iss.is_div &&
                    iss.divisor_zero;
  assign c_trc    = iss_valid && !nop_hold &&
                    (iss.is_stop ? iss.stop_sets_trace : sr_trace);

  // ----------------------------------------------------------------
  // priority select, one report per instruction
  // ----------------------------------------------------------------
  always_comb begin
    rep_nxt  = '0;
    take_nxt = 1'b1;
    if (c_rd) begin
      rep_nxt.vector       = VEC_ACCESS;
      rep_nxt.fs           = FS_READ;
      rep_nxt.keep_updates = 1'b1;
    end else if (c_pf) begin
      rep_nxt.vector = VEC_ACCESS;
      rep_nxt.fs     = FS_FETCH;
    end else if (c_wr) begin
      rep_nxt.vector       = VEC_ACCESS;
      rep_nxt.fs           = FS_WRITE;
      rep_nxt.keep_updates = 1'b1;
    end else if (c_ill) begin
      rep_nxt.vector = dec.ill_vec;
    end else if (c_priv) begin
      rep_nxt.vector = VEC_PRIV;
    end else if (c_idx) begin
      rep_nxt.vector = VEC_ADDR;
      rep_nxt.fs     = FS_READ;
    end else if (c_odd) begin
      rep_nxt.vector   = VEC_ADDR;
      rep_nxt.fs       = FS_FETCH;
      rep_nxt.push_ret = iss.is_jsr;
      rep_nxt.over_ret = iss.is_rts;
    end else if (c_div) begin
      rep_nxt.vector = VEC_DIVZ;
    end else if (c_trc) begin
      // trace only when nothing else taken
      rep_nxt.vector  = VEC_TRACE;
      rep_nxt.pc_next = 1'b1;
    end else begin
      take_nxt = 1'b0;
    end
    rep_nxt.offset = cfed_vec_ofs(rep_nxt.vector);
  end

  // report register
  always_ff @(posedge clk) begin
    if (rst) begin
      exc_valid_r <= 1'b0;
      exc_r       <= '0;
    end else begin
      exc_valid_r <= take_nxt;
      exc_r       <= take_nxt ? rep_nxt : '0;
    end
  end

  // ----------------------------------------------------------------
  // pending fetch and write errors
  // ----------------------------------------------------------------
  // hold until used; only the fetch error drops on flush
  always_ff @(posedge clk) begin
    if (rst) begin
      pf_pend_r <= 1'b0;
    end else begin
      pf_pend_r <= pf_err ||
                   (pf_pend_r && !pf_flush && !(c_pf && !c_rd));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_pend_r <= 1'b0;
    end else begin
      wr_pend_r <= wr_err || (wr_pend_r && !(c_wr && !c_rd));
    end
  end

  // ----------------------------------------------------------------
  // no-op drain state
  // ----------------------------------------------------------------
  always_comb begin
    case (st_r)
      CFED_RUN:  st_nxt = (nop_hold && !c_rd) ? CFED_NOPW : CFED_RUN;
      CFED_NOPW: st_nxt = (nop_hold && !c_rd) ? CFED_NOPW : CFED_RUN;
      default:   st_nxt = CFED_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r        <= CFED_RUN;
      nop_stall_r <= 1'b0;
    end else begin
      st_r        <= st_nxt;
      nop_stall_r <= (st_nxt == CFED_NOPW);
    end
  end

  // ----------------------------------------------------------------
  // observation registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      last_vec_r <= VEC_NONE;
      last_fs_r  <= FS_NONE;
    end else if (take_nxt) begin
      last_vec_r <= rep_nxt.vector;
      last_fs_r  <= rep_nxt.fs;
    end
  end

  // exception counter, cleared by a write unless an exception is counted in that cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= CNT_RST;
    end else if (take_nxt) begin
      cnt_r <= cnt_r + 16'h0001;
    end else if (acc_ok && avs_write && avs_address == REG_CNT) begin
      cnt_r <= CNT_RST;
    end
  end

  // ----------------------------------------------------------------
  // avalon-mm slave, one wait cycle per access
  // ----------------------------------------------------------------
  assign acc_ok = !avs_waitrequest;

  always_ff @(posedge clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  // read data stands at the sampling edge
  always_ff @(posedge clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        REG_CTRL: avs_readdata <= {31'h0000_0000, uha_r};
        REG_STAT: avs_readdata <= {17'h0_0000, nop_stall_r, pf_pend_r,
                                   wr_pend_r, last_fs_r, last_vec_r};
        REG_CNT:  avs_readdata <= {16'h0000, cnt_r};
        default:  avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // control register
  always_ff @(posedge clk) begin
    if (rst) begin
      uha_r <= CTRL_UHA_RST;
    end else if (acc_ok && avs_write && avs_address == REG_CTRL) begin
      uha_r <= avs_writedata[CTRL_UHA_BIT];
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pf_left;
    pf_err ##1 (!pf_flush && !iss_valid)[*2];
  endsequence

  sequence s_nop_wait;
    iss_valid && iss.is_nop && wr_busy && !rd_err;
  endsequence

  chk_read_abort: assert property (
    rd_err |=> exc_valid_r && exc_r.fs == FS_READ && exc_r.keep_updates)
    else $error("read fault not reported at once");

  chk_fetch_held: assert property (
    s_pf_left |-> ##1 pf_pend_r)
    else $error("fetch fault not held");

  chk_fetch_flush: assert property (
    pf_flush && !pf_err |=> !pf_pend_r)
    else $error("flushed fetch fault kept");

  chk_write_sticky: assert property (
    wr_err |=> wr_pend_r)
    else $error("write fault lost");

  chk_nop_stall: assert property (
    s_nop_wait |=> nop_stall_r && !(exc_valid_r && exc_r.fs == FS_WRITE))
    else $error("no-op did not wait for writes");

  chk_odd_target: assert property (
    c_odd && !(c_rd || c_pf || c_wr || c_ill || c_priv || c_idx)
    |=> exc_r.vector == VEC_ADDR && exc_r.fs == FS_FETCH)
    else $error("odd target not trapped");

  chk_div_zero: assert property (
    c_div && !(c_rd || c_pf || c_wr || c_ill || c_priv || c_idx || c_odd)
    |=> exc_r.vector == VEC_DIVZ && exc_r.offset == OFS_DIVZ)
    else $error("divide by zero vector wrong");

  chk_halt_user: assert property (
    iss_valid && iss.is_halt && uha_r && !rd_err |=> exc_r.vector != VEC_PRIV)
    else $error("allowed halt raised privilege fault");

  chk_stop_trace: assert property (
    iss_valid && iss.is_stop && !iss.stop_sets_trace && sr_trace
    |=> exc_r.vector != VEC_TRACE)
    else $error("stop traced without loaded flag");

  chk_single_exc: assert property (
    c_trc && c_div |=> exc_valid_r && exc_r.vector != VEC_TRACE)
    else $error("trace taken beside another fault");

  chk_fetch_code: assert property (
    c_pf && !c_rd |=> exc_r.fs == FS_FETCH && !exc_r.keep_updates)
    else $error("fetch fault status wrong");

  chk_line_vec: assert property (
    c_ill && !(c_rd || c_pf || c_wr) && dec.line == LINE_F
    |=> exc_valid_r && exc_r.vector == VEC_LINE_F)
    else $error("line f opcode vector wrong");

  chk_priv_user: assert property (
    iss_valid && iss.super_only && !iss.is_halt && !sr_super &&
    !nop_hold && !rd_err && !pf_hit && !wr_pend_r && !dec.illegal
    |=> exc_valid_r && exc_r.vector == VEC_PRIV)
    else $error("user mode supervisor instruction ran");

endmodule // cfed_fault_detect

// ### rtl/cfed_pkg.sv
package cfed_pkg;

  // ----------------------------------------------------------------
  // exception vectors and table offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_NONE    = 8'h00;
  localparam logic [7:0] VEC_ACCESS  = 8'h02;
  localparam logic [7:0] VEC_ADDR    = 8'h03;
  localparam logic [7:0] VEC_ILLEGAL = 8'h04;
  localparam logic [7:0] VEC_DIVZ    = 8'h05;
  localparam logic [7:0] VEC_PRIV    = 8'h08;
  localparam logic [7:0] VEC_TRACE   = 8'h09;
  localparam logic [7:0] VEC_LINE_A  = 8'h0a;
  localparam logic [7:0] VEC_LINE_F  = 8'h0b;
  localparam logic [9:0] OFS_DIVZ    = 10'h014;

  // fault status field codes
  localparam logic [3:0] FS_NONE  = 4'h0;
  localparam logic [3:0] FS_FETCH = 4'h4;
  localparam logic [3:0] FS_WRITE = 4'h8;
  localparam logic [3:0] FS_READ  = 4'hc;

  // ----------------------------------------------------------------
  // opword and extension word layout
  // ----------------------------------------------------------------
  localparam int OPW_LINE_HI = 15;
  localparam int OPW_LINE_LO = 12;
  localparam int OPW_MODE_HI = 11;
  localparam int OPW_MODE_LO = 6;
  localparam int OPW_EA_HI   = 5;
  localparam int OPW_EA_LO   = 0;
  localparam logic [3:0] LINE_A = 4'ha;
  localparam logic [3:0] LINE_F = 4'hf;
  localparam int EXT_WL_BIT   = 11;
  localparam int EXT_SCALE_HI = 10;
  localparam int EXT_SCALE_LO = 9;
  localparam int EXT_FULL_BIT = 8;
  localparam logic [1:0] SCALE_EIGHT = 2'h3;
  localparam logic [1:0] WORDS_ONE   = 2'h1;
  localparam logic [1:0] WORDS_TWO   = 2'h2;
  localparam logic [1:0] WORDS_THREE = 2'h3;

  // ----------------------------------------------------------------
  // register map (byte addresses) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0]  REG_CTRL  = 4'h0;
  localparam logic [3:0]  REG_STAT  = 4'h4;
  localparam logic [3:0]  REG_CNT   = 4'h8;
  localparam int          CTRL_UHA_BIT = 0;
  localparam logic        CTRL_UHA_RST = 1'b0;
  localparam int          STAT_FS_LO   = 8;
  localparam int          STAT_WR_BIT  = 12;
  localparam int          STAT_PF_BIT  = 13;
  localparam int          STAT_NOP_BIT = 14;
  localparam logic [15:0] CNT_RST      = 16'h0000;

  typedef enum logic [1:0] {
    CFED_RUN  = 2'b01,
    CFED_NOPW = 2'b10
  } cfed_state_t;

  // instruction at the execute stage, from pipeline and decoder
  typedef struct packed {
    logic [15:0] opword;
    logic [15:0] ext1;
    logic        has_ext1;
    logic        has_ext2;
    logic        op_defined;
    logic        is_mac;
    logic        uses_pf_word;
    logic        is_flow;
    logic        target_odd;
    logic        is_jsr;
    logic        is_rts;
    logic        has_index;
    logic        is_div;
    logic        divisor_zero;
    logic        super_only;
    logic        is_halt;
    logic        is_stop;
    logic        stop_sets_trace;
    logic        is_nop;
  } cfed_issue_t;

  typedef struct packed {
    logic [3:0] line;
    logic [5:0] mode;
    logic [5:0] ea;
    logic [1:0] words;
    logic       illegal;
    logic [7:0] ill_vec;
    logic       idx_bad;
  } cfed_decode_t;

  typedef struct packed {
    logic [7:0] vector;
    logic [9:0] offset;
    logic [3:0] fs;
    logic       pc_next;
    logic       keep_updates;
    logic       push_ret;
    logic       over_ret;
  } cfed_report_t;

  // vector table byte offset
  function automatic logic [9:0] cfed_vec_ofs(input logic [7:0] v);
    return {v, 2'b00};
  endfunction

endpackage

// ### rtl/cfed_opword_decode.sv
module cfed_opword_decode
  import cfed_pkg::*;
(
  input  wire logic [15:0] opword,
  input  wire logic [15:0] ext1,
  input  wire logic        has_ext1,
  input  wire logic        has_ext2,
  input  wire logic        op_defined,
  input  wire logic        is_mac,
  input  wire logic        has_index,
  output cfed_decode_t     dec
);

  // ----------------------------------------------------------------
  // opword fields, length and illegal classification
  // ----------------------------------------------------------------
  always_comb begin
    dec         = '0;
    dec.line    = opword[OPW_LINE_HI:OPW_LINE_LO];
    dec.mode    = opword[OPW_MODE_HI:OPW_MODE_LO];
    dec.ea      = opword[OPW_EA_HI:OPW_EA_LO];
    dec.words   = has_ext2 ? WORDS_THREE :
                  (has_ext1 ? WORDS_TWO : WORDS_ONE);
    dec.illegal = !op_defined;
    if (dec.line == LINE_A && !is_mac) begin
      dec.ill_vec = VEC_LINE_A;
    end else if (dec.line == LINE_F) begin
      dec.ill_vec = VEC_LINE_F;
    end else begin
      dec.ill_vec = VEC_ILLEGAL;
    end
    dec.idx_bad = has_index && (!ext1[EXT_WL_BIT] ||
                  ext1[EXT_SCALE_HI:EXT_SCALE_LO] == SCALE_EIGHT ||
                  ext1[EXT_FULL_BIT]);
  end

endmodule // cfed_opword_decode

// ### test/cfed_bus_model.sv
module cfed_bus_model (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic go,
  input  wire logic fail,
  output logic      wr_busy,
  output logic      wr_err
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [3:0] cnt_r;
  logic       fail_r;

  // ---------------------------------------------------------------
  // buffered write drain
  // ---------------------------------------------------------------
  // write ends after six cycles, error pulse in the cycle busy drops
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r  <= 4'h0;
      fail_r <= 1'b0;
      wr_err <= 1'b0;
    end else begin
      wr_err <= fail_r && (cnt_r == 4'h1);
      if (go) begin
        cnt_r  <= 4'h6;
        fail_r <= fail;
      end else if (cnt_r != 4'h0) begin
        cnt_r <= cnt_r - 4'h1;
      end
    end
  end

  assign wr_busy = (cnt_r != 4'h0); // level while a write is outstanding
endmodule // cfed_bus_model

// ### test/tb_top.sv
module tb_top
  import cfed_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic         clk, rst, avs_read, avs_write, avs_waitrequest;
  logic [3:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, rd;
  logic         iss_valid, sr_trace, sr_super, pf_err, pf_flush, rd_err;
  logic         wr_go, wr_fail, wr_busy, wr_err, exc_valid_r, nop_stall_r;
  cfed_issue_t  iss, b, w;
  localparam int CYC_MAX = 5000; // far above the run's length
  cfed_report_t exc_r;
  int           error_cnt, n_tests, exp_cnt, cyc;
  logic [15:0]  xt [4];

  cfed_fault_detect u_cfed_fault_detect (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .iss_valid(iss_valid), .iss(iss),
    .sr_trace(sr_trace), .sr_super(sr_super), .pf_err(pf_err),
    .pf_flush(pf_flush), .rd_err(rd_err), .wr_err(wr_err),
    .wr_busy(wr_busy), .exc_valid_r(exc_valid_r), .exc_r(exc_r),
    .nop_stall_r(nop_stall_r));
  cfed_bus_model u_cfed_bus_model (.clk(clk), .rst(rst), .go(wr_go),
    .fail(wr_fail), .wr_busy(wr_busy), .wr_err(wr_err));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == CYC_MAX) stop_test();
  end

  // a hang counts as one mismatch
  task automatic stop_test();
    int bad;
    bad = error_cnt + ((cyc >= CYC_MAX) ? 1 : 0);
    $display("checks %0d mismatches %0d", n_tests, bad);
    if (bad == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [63:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // avalon access, held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [3:0] a,
                     input logic [31:0] wd);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // one instruction at execute, report checked one edge later
  task automatic issue(input string nm, input cfed_issue_t i,
                       input logic r, input logic v, input logic [7:0] vec,
                       input logic [3:0] fs, fl, m);
    @(posedge clk);
    iss_valid <= 1'b1;
    iss       <= i;
    rd_err    <= r;
    @(posedge clk);
    iss_valid <= 1'b0;
    rd_err    <= 1'b0;
    #1;
    chk({nm, " valid"}, exc_valid_r, v);
    if (v) exp_cnt++;
    chk({nm, " vector"}, exc_r.vector, v ? vec : 8'h00);
    chk({nm, " offset"}, exc_r.offset, v ? {vec, 2'b00} : 10'h000);
    chk({nm, " fs"}, exc_r.fs, v ? fs : 4'h0);
    chk({nm, " flags"}, exc_r[3:0] & m, fl & m);
    $display("test %s done", nm);
  endtask

  task automatic pulse(input logic e, f);
    @(posedge clk);
    pf_err   <= e;
    pf_flush <= f;
    @(posedge clk);
    pf_err   <= 1'b0;
    pf_flush <= 1'b0;
  endtask

  initial begin
    {rst, avs_read, avs_write, iss_valid, sr_trace, sr_super} = 6'h21;
    {pf_err, pf_flush, rd_err, wr_go, wr_fail} = 5'h00;
    {avs_address, avs_writedata, iss, rd} = '0;
    xt = '{16'h0000, 16'h0e00, 16'h0900, 16'h0800};
    b = '0;
    b.opword = 16'h2001;
    b.op_defined = 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // reset values and an unmapped place
    avs(1'b0, REG_CTRL, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    avs(1'b0, REG_CNT, 32'h0);
    chk("count reset", rd, 32'h0);
    avs(1'b1, 4'hc, 32'hffff_ffff);
    avs(1'b0, 4'hc, 32'h0);
    chk("unmapped", rd, 32'h0);
    issue("plain", b, 0, 0, 0, 0, 0, 4'hf);
    // divide by zero, then a read error that wins over it
    w = b;
    w.is_div = 1'b1;
    w.divisor_zero = 1'b1;
    issue("div0", w, 0, 1, 8'h05, 4'h0, 4'h0, 4'hf);
    issue("rd_err", w, 1, 1, 8'h02, 4'hc, 4'h4, 4'hf);
    // opword lines
    w = b;
    w.op_defined = 1'b0;
    w.opword = 16'h4a00;
    issue("ill4", w, 0, 1, 8'h04, 4'h0, 4'h0, 4'hf);
    w.opword = 16'ha123;
    issue("linea", w, 0, 1, 8'h0a, 4'h0, 4'h0, 4'hf);
    w.opword = 16'hf123;
    issue("linef", w, 0, 1, 8'h0b, 4'h0, 4'h0, 4'hf);
    // extension words never make an opcode illegal
    w = b;
    w.ext1 = 16'hffff;
    w.has_ext1 = 1'b1;
    w.has_ext2 = 1'b1;
    issue("ext", w, 0, 0, 0, 0, 0, 4'hf);
    // bad index forms; long index scale one is fine
    for (int k = 0; k < 4; k++) begin
      w = b;
      w.has_index = 1'b1;
      w.has_ext1 = 1'b1;
      w.ext1 = xt[k];
      issue("index", w, 0, k < 3, 8'h03, 4'hc, 4'h0, 4'hf);
    end
    // odd targets
    w = b;
    w.is_flow = 1'b1;
    w.target_odd = 1'b1;
    w.is_jsr = 1'b1;
    issue("jsr", w, 0, 1, 8'h03, 4'h4, 4'h2, 4'hf);
    w.is_jsr = 1'b0;
    w.is_rts = 1'b1;
    issue("rts", w, 0, 1, 8'h03, 4'h4, 4'h1, 4'hf);
    w.is_rts = 1'b0;
    w.target_odd = 1'b0;
    issue("even", w, 0, 0, 0, 0, 0, 4'hf);
    // privilege and user halt
    @(posedge clk) sr_super <= 1'b0;
    w = b;
    w.super_only = 1'b1;
    issue("priv", w, 0, 1, 8'h08, 4'h0, 4'h0, 4'hf);
    w.is_halt = 1'b1;
    issue("halt", w, 0, 1, 8'h08, 4'h0, 4'h0, 4'hf);
    avs(1'b1, REG_CTRL, 32'h1);
    avs(1'b0, REG_CTRL, 32'h0);
    chk("ctrl", rd, 32'h1);
    issue("uhalt", w, 0, 0, 0, 0, 0, 4'hf);
    @(posedge clk) sr_super <= 1'b1;
    // trace and stop; a divide fault pushes the trace aside
    @(posedge clk) sr_trace <= 1'b1;
    issue("trace", b, 0, 1, 8'h09, 4'h0, 4'h8, 4'hf);
    w = b;
    w.is_div = 1'b1;
    w.divisor_zero = 1'b1;
    issue("divtrc", w, 0, 1, 8'h05, 4'h0, 4'h0, 4'hf);
    w = b;
    w.is_stop = 1'b1;
    issue("stop_t", w, 0, 0, 0, 0, 0, 4'hf);
    @(posedge clk) sr_trace <= 1'b0;
    w.stop_sets_trace = 1'b1;
    issue("stop_s", w, 0, 1, 8'h09, 4'h0, 4'h8, 4'hf);
    // fetch faults: flushed one is dropped, used one aborts
    w = b;
    w.uses_pf_word = 1'b1;
    pulse(1, 0);
    pulse(0, 1);
    issue("flushed", w, 0, 0, 0, 0, 0, 4'hf);
    pulse(1, 0);
    avs(1'b0, REG_STAT, 32'h0);
    chk("stat fetch", rd, 32'h0000_2009);
    issue("fetch", w, 0, 1, 8'h02, 4'h4, 4'h0, 4'h4);
    // no-op waits for the buffered write and takes its error
    w = b;
    w.is_nop = 1'b1;
    @(posedge clk);
    wr_go   <= 1'b1;
    wr_fail <= 1'b1;
    @(posedge clk);
    wr_go     <= 1'b0;
    iss_valid <= 1'b1;
    iss       <= w;
    @(posedge clk) #1;
    chk("nop stall", nop_stall_r, 1'b1);
    while (nop_stall_r === 1'b1) begin
      chk("nop quiet", exc_valid_r, 1'b0);
      @(posedge clk) #1;
    end
    chk("nop report", exc_valid_r, 1'b1);
    chk("nop fs", {exc_r.vector, exc_r.fs}, {8'h02, 4'h8});
    chk("nop keep", exc_r.keep_updates, 1'b1);
    exp_cnt++;
    @(posedge clk);
    iss_valid <= 1'b0;
    avs(1'b0, REG_STAT, 32'h0);
    chk("stat write", rd, 32'h0000_0802);
    // report counter, cleared by a write
    avs(1'b0, REG_CNT, 32'h0);
    chk("count", rd, exp_cnt);
    avs(1'b1, REG_CNT, 32'h0);
    avs(1'b0, REG_CNT, 32'h0);
    chk("count clr", rd, 32'h0);
    stop_test();
  end
endmodule // tb_top
